// ===== core/usf_status.sv
// serial port status flags, transmitter shutdown and apb registers
//
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "usf_regs.svh"
// What this block does
// - flags set by hardware, held until cleared
// - enabling transmitter sets empty and complete
// - empty flag whenever holding register free
// - empty flag and its enable request interrupt
// - complete flag when queue fully sent
// - complete flag and its enable request interrupt
// - clearing enable lets current character finish
// - only reset stops transmitter mid-character
// - idle disable returns pin on bit tick
// - disable during send discards queued character
// - flags still set after final character
// - five receive flags, three can interrupt
// - overrun drops new character, keeps old
// - ready flag set on transfer to holding
// - overrun set instead of ready flag
// - noise and framing describe held character, no irq
// - idle after one character time of ones
// - idle flag only on busy-to-idle transition
// - status readable without disturbing reception
// - bit clock is sample tick divided by sixteen
module usf_status (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic rx_char_valid_i,
  input wire logic [7:0] rx_char_i,
  input wire logic rx_noise_i,
  input wire logic rx_frame_err_i,
  input wire logic rxd_i,
  output logic txd_o,
  output logic txd_oe_n_o,
  output logic irq_o
);
  usf_tick_if tk();
  usf_pkg::usf_tx_state_e tx_state_reg;
  logic [31:0] ctrl_reg;
  logic [15:0] baud_reg;
  logic [15:0] pre_cnt_reg;
  logic [3:0] ovs_cnt_reg;
  logic sample_tick_reg;
  logic bit_tick_reg;
  logic tx_empty_flag_reg, tx_complete_flag_reg, rx_ready_flag_reg, or_reg;
  logic noise_flag_reg, framing_error_flag_reg, idle_reg;
  logic [7:0] txq_reg;
  logic [7:0] tx_shift_reg;
  logic [3:0] tx_bit_reg;
  logic tx_pin_reg;
  logic txd_oe_n_reg;
  logic [7:0] rxh_reg;
  logic stat_read_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic irq_reg;
  logic txd_reg;
  logic wr_acc, rd_acc, tx_enable, tx_enable_rise, wr_txd, rd_rxd;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction

  // two-cycle access phase: pready rises one clock after penable
  assign wr_acc = psel_i && penable_i && pwrite_i && !pready_reg;
  assign rd_acc = psel_i && penable_i && !pwrite_i && !pready_reg;
  assign tx_enable = ctrl_reg[`USF_CTRL_TX_EN];
  assign tx_enable_rise = wr_acc && hit(paddr_i, `USF_OFF_CTRL) && pwdata_i[`USF_CTRL_TX_EN]
    && !tx_enable;
  assign wr_txd = wr_acc && hit(paddr_i, `USF_OFF_TXD);
  assign rd_rxd = rd_acc && hit(paddr_i, `USF_OFF_RXD);
  assign tk.bit_tick = bit_tick_reg;

  usf_idle_det #(.CHAR_BITS(`USF_CHAR_BITS)) u_idle (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .rxd_i(rxd_i),
    .tk(tk)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= `USF_CTRL_RST;
      baud_reg <= `USF_BAUD_RST;
    end else if (wr_acc && hit(paddr_i, `USF_OFF_CTRL)) begin
      ctrl_reg <= {27'h0, pwdata_i[4:0]}; // writes never stop a character
    end else if (wr_acc && hit(paddr_i, `USF_OFF_BAUD)) begin
      baud_reg <= (pwdata_i[15:0] == 16'h0000) ? 16'h0001 : pwdata_i[15:0];
    end
  end

  // prescaler makes the sample tick; the bit tick is every sixteenth of those
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_cnt_reg <= 16'h0000;
      ovs_cnt_reg <= 4'h0;
      sample_tick_reg <= 1'b0;
      bit_tick_reg <= 1'b0;
    end else begin
      sample_tick_reg <= 1'b0;
      bit_tick_reg <= 1'b0;
      if (pre_cnt_reg >= baud_reg - 16'h0001) begin
        pre_cnt_reg <= 16'h0000;
        sample_tick_reg <= 1'b1;
      end else begin
        pre_cnt_reg <= pre_cnt_reg + 16'h0001;
      end
      if (sample_tick_reg) begin
        ovs_cnt_reg <= ovs_cnt_reg + 4'h1;
        if (ovs_cnt_reg == 4'(`USF_OVS - 1)) begin
          bit_tick_reg <= 1'b1;
        end
      end
    end
  end

  // transmitter: one-deep queue plus shifter, 8N1 framing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_state_reg <= usf_pkg::USF_TX_IDLE;
      tx_shift_reg <= 8'h00;
      tx_bit_reg <= 4'h0;
      tx_pin_reg <= 1'b1;
      txq_reg <= 8'h00;
    end else begin
      if (wr_txd && tx_enable) begin
        txq_reg <= pwdata_i[7:0];
      end
      case (tx_state_reg)
        usf_pkg::USF_TX_IDLE: begin
          tx_pin_reg <= 1'b1;
          if (bit_tick_reg && tx_enable && !tx_empty_flag_reg) begin
            tx_shift_reg <= txq_reg;
            tx_bit_reg <= 4'h0;
            tx_pin_reg <= 1'b0;
            tx_state_reg <= usf_pkg::USF_TX_SHIFT;
          end
        end
        usf_pkg::USF_TX_SHIFT: begin
          // keeps shifting even with the enable low
          if (bit_tick_reg) begin
            tx_bit_reg <= tx_bit_reg + 4'h1;
            if (tx_bit_reg == 4'h8) begin
              tx_pin_reg <= 1'b1;
            end else if (tx_bit_reg == 4'h9) begin
              tx_state_reg <= usf_pkg::USF_TX_IDLE;
            end else begin
              tx_pin_reg <= tx_shift_reg[0];
              tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
            end
          end
        end
        default: tx_state_reg <= usf_pkg::USF_TX_IDLE;
      endcase
    end
  end

  logic tx_load, tx_done;
  assign tx_load = (tx_state_reg == usf_pkg::USF_TX_IDLE) && bit_tick_reg && tx_enable
    && !tx_empty_flag_reg;
  assign tx_done = (tx_state_reg == usf_pkg::USF_TX_SHIFT) && bit_tick_reg && tx_bit_reg == 4'h9;

  // pin ownership handed back only on a bit tick while idle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      txd_oe_n_reg <= 1'b1;
    end else if (tx_enable) begin
      txd_oe_n_reg <= 1'b0;
    end else if (bit_tick_reg && tx_state_reg == usf_pkg::USF_TX_IDLE) begin
      txd_oe_n_reg <= 1'b1;
    end
  end

  // transmit flags; clear sequence: status read then data write; set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_empty_flag_reg <= 1'b0;
      tx_complete_flag_reg <= 1'b0;
    end else begin
      if (tx_enable_rise) begin
        tx_empty_flag_reg <= 1'b1;
        tx_complete_flag_reg <= 1'b1;
      end else if (tx_done && !tx_enable) begin
        tx_empty_flag_reg <= 1'b1;
        tx_complete_flag_reg <= 1'b1;
      end else begin
        if (tx_load) begin
          tx_empty_flag_reg <= 1'b1;
        end else if (wr_txd && tx_enable && stat_read_reg) begin
          tx_empty_flag_reg <= 1'b0;
        end
        if (tx_done && tx_empty_flag_reg) begin
          tx_complete_flag_reg <= 1'b1;
        end else if (wr_txd && tx_enable && stat_read_reg) begin
          tx_complete_flag_reg <= 1'b0;
        end
      end
      if (!tx_enable && !tx_empty_flag_reg && tx_state_reg == usf_pkg::USF_TX_SHIFT) begin
        tx_empty_flag_reg <= 1'b1; // queued character dropped
      end
    end
  end

  // receive flags; clear sequence: status read then data read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_ready_flag_reg <= 1'b0;
      or_reg <= 1'b0;
      noise_flag_reg <= 1'b0;
      framing_error_flag_reg <= 1'b0;
      idle_reg <= 1'b0;
      rxh_reg <= 8'h00;
    end else begin
      if (rd_rxd && stat_read_reg) begin
        rx_ready_flag_reg <= 1'b0;
        or_reg <= 1'b0;
        idle_reg <= 1'b0;
      end
      if (rx_char_valid_i) begin
        if (rx_ready_flag_reg && !(rd_rxd && stat_read_reg)) begin
          or_reg <= 1'b1;
        end else begin
          rxh_reg <= rx_char_i;
          rx_ready_flag_reg <= 1'b1;
          noise_flag_reg <= rx_noise_i;
          framing_error_flag_reg <= rx_frame_err_i;
        end
      end
      if (tk.idle_edge) begin
        idle_reg <= 1'b1;
      end
    end
  end

  // arm the clear sequence on a status read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_read_reg <= 1'b0;
    end else if (rd_acc && hit(paddr_i, `USF_OFF_STAT)) begin
      stat_read_reg <= 1'b1;
    end else if (wr_txd || rd_rxd) begin
      stat_read_reg <= 1'b0;
    end
  end

  // apb slave: one wait state, unmapped addresses answer with pslverr
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= psel_i && penable_i && !pready_reg;
      pslverr_reg <= 1'b0;
      if (psel_i && penable_i && !pready_reg) begin
        prdata_reg <= 32'h0000_0000;
        case (paddr_i)
          `USF_OFF_CTRL: prdata_reg <= ctrl_reg;
          `USF_OFF_STAT: prdata_reg <= {23'h0, !txd_oe_n_reg,
            tx_state_reg == usf_pkg::USF_TX_SHIFT, idle_reg, framing_error_flag_reg,
            noise_flag_reg, or_reg, rx_ready_flag_reg, tx_complete_flag_reg,
            tx_empty_flag_reg};
          `USF_OFF_RXD: prdata_reg <= {24'h0, rxh_reg};
          `USF_OFF_TXD: prdata_reg <= 32'h0000_0000;
          `USF_OFF_BAUD: prdata_reg <= {16'h0, baud_reg};
          default: pslverr_reg <= 1'b1;
        endcase
      end
    end
  end

  // outputs from flip-flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_reg <= 1'b0;
      txd_reg <= 1'b1;
    end else begin
      irq_reg <= (ctrl_reg[`USF_CTRL_TX_EMPTY_IE] && tx_empty_flag_reg)
        || (ctrl_reg[`USF_CTRL_TX_DONE_IE] && tx_complete_flag_reg)
        || (ctrl_reg[`USF_CTRL_RIE] && (rx_ready_flag_reg || or_reg))
        || (ctrl_reg[`USF_CTRL_ILIE] && idle_reg);
      txd_reg <= tx_pin_reg;
    end
  end
  assign prdata_o = prdata_reg;
  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;
  assign irq_o = irq_reg;
  assign txd_o = txd_reg;
  assign txd_oe_n_o = txd_oe_n_reg;

  property p_empty_irq;
    @(posedge clk_i) disable iff (rst_i)
      (ctrl_reg[`USF_CTRL_TX_EMPTY_IE] && tx_empty_flag_reg) |=> irq_o;
  endproperty
  a_empty_irq: assert property (p_empty_irq) else $error("empty irq missing");
  property p_done_irq;
    @(posedge clk_i) disable iff (rst_i)
      (ctrl_reg[`USF_CTRL_TX_DONE_IE] && tx_complete_flag_reg) |=> irq_o;
  endproperty
  a_done_irq: assert property (p_done_irq) else $error("complete irq missing");
  property p_enable_on;
    @(posedge clk_i) disable iff (rst_i)
      tx_enable_rise |=> (tx_empty_flag_reg && tx_complete_flag_reg);
  endproperty
  a_enable_on: assert property (p_enable_on) else $error("enable did not set flags");
  property p_quiet_irq;
    @(posedge clk_i) disable iff (rst_i) (ctrl_reg[4:1] == 4'h0) |=> !irq_o;
  endproperty
  a_quiet_irq: assert property (p_quiet_irq) else $error("irq without enable");
  property p_idle_level;
    @(posedge clk_i) disable iff (rst_i) tk.idle_edge |-> tk.line_idle;
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("idle edge on busy line");
  property p_no_abort;
    @(posedge clk_i) disable iff (rst_i)
      (tx_state_reg == usf_pkg::USF_TX_SHIFT && !tx_done) |=>
        tx_state_reg == usf_pkg::USF_TX_SHIFT;
  endproperty
  a_no_abort: assert property (p_no_abort) else $error("character aborted");
  property p_last_flags;
    @(posedge clk_i) disable iff (rst_i)
      (tx_done && !tx_enable) |=> (tx_complete_flag_reg && tx_empty_flag_reg);
  endproperty
  a_last_flags: assert property (p_last_flags) else $error("last char flags");
  property p_overrun;
    @(posedge clk_i) disable iff (rst_i)
      (rx_char_valid_i && rx_ready_flag_reg && !rd_rxd) |=> (or_reg && $stable(rxh_reg));
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun kept char");
  property p_ready;
    @(posedge clk_i) disable iff (rst_i)
      (rx_char_valid_i && !rx_ready_flag_reg) |=> rx_ready_flag_reg;
  endproperty
  a_ready: assert property (p_ready) else $error("ready not set");
  property p_idle_once;
    @(posedge clk_i) disable iff (rst_i) tk.idle_edge |=> !tk.idle_edge;
  endproperty
  a_idle_once: assert property (p_idle_once) else $error("idle edge repeated");
  property p_pin_back;
    @(posedge clk_i) disable iff (rst_i)
      (!tx_enable && txd_oe_n_reg) |-> tx_state_reg == usf_pkg::USF_TX_IDLE;
  endproperty
  a_pin_back: assert property (p_pin_back) else $error("pin released busy");
  c_tx_done: cover property (@(posedge clk_i) tx_done);
  c_overrun: cover property (@(posedge clk_i) rx_char_valid_i && rx_ready_flag_reg);
  c_idle: cover property (@(posedge clk_i) tk.idle_edge);
endmodule // usf_status

// ===== core/usf_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef USF_REGS_SVH
`define USF_REGS_SVH
`define USF_OFF_CTRL 12'h000
`define USF_OFF_STAT 12'h004
`define USF_OFF_TXD 12'h008
`define USF_OFF_RXD 12'h00C
`define USF_OFF_BAUD 12'h010
`define USF_CTRL_TX_EN 0
`define USF_CTRL_TX_EMPTY_IE 1
`define USF_CTRL_TX_DONE_IE 2
`define USF_CTRL_RIE 3
`define USF_CTRL_ILIE 4
`define USF_ST_TX_EMPTY 0
`define USF_ST_TX_DONE 1
`define USF_ST_RX_READY 2
`define USF_ST_OR 3
`define USF_ST_NOISE 4
`define USF_ST_FRAME 5
`define USF_ST_IDLE 6
`define USF_ST_TXACT 7
`define USF_ST_TXPIN 8
`define USF_CTRL_RST 32'h0000_0000
`define USF_BAUD_RST 16'h0019
`define USF_OVS 16
`define USF_CHAR_BITS 10
`endif

// ===== core/usf_pkg.sv
// shared types of the serial-port status block
package usf_pkg;
  typedef enum logic [1:0] {
    USF_TX_IDLE = 2'b00,
    USF_TX_SHIFT = 2'b01
  } usf_tx_state_e;
endpackage

// ===== core/usf_tick_if.sv
// tick and line-status carrier between the top and the idle detector
`timescale 1ns/1ps
interface usf_tick_if;
  logic bit_tick;
  logic line_idle;
  logic idle_edge;
  modport src (output bit_tick, input line_idle, input idle_edge);
  modport det (input bit_tick, output line_idle, output idle_edge);
endinterface

// ===== core/usf_idle_det.sv
// receive line idle detector, counts one character time of ones
`timescale 1ns/1ps
`include "usf_regs.svh"
module usf_idle_det #(
  parameter int CHAR_BITS = `USF_CHAR_BITS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic rxd_i,
  usf_tick_if.det tk
);
  logic [4:0] cnt_reg;
  logic idle_reg;
  logic edge_reg;
  if (CHAR_BITS < 2 || CHAR_BITS > 31) begin : g_bad_char_bits
    $error("usf_idle_det: CHAR_BITS out of range");
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= 5'h00;
      idle_reg <= 1'b1;
      edge_reg <= 1'b0;
    end else begin
      edge_reg <= 1'b0;
      if (!rxd_i) begin
        cnt_reg <= 5'h00;
        idle_reg <= 1'b0;
      end else if (tk.bit_tick && !idle_reg) begin
        if (cnt_reg == 5'(CHAR_BITS - 1)) begin
          idle_reg <= 1'b1;
          edge_reg <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + 5'h01;
        end
      end
    end
  end
  assign tk.line_idle = idle_reg;
  assign tk.idle_edge = edge_reg;
endmodule // usf_idle_det

// ===== tb/usf_remote.sv
// remote serial device: drives the receive side and decodes the transmit line
`timescale 1ns/1ps
module usf_remote (
  input wire logic clk_i,
  input wire logic txd_i,
  input wire logic listen_i,
  output logic rxd_o,
  output logic rx_valid_o,
  output logic [7:0] rx_char_o,
  output logic rx_noise_o,
  output logic rx_ferr_o
);
  int bit_cyc = 16;
  logic [7:0] got_byte;
  logic got_stop;
  event got;
  initial begin
    rxd_o = 1'b1;
    rx_valid_o = 1'b0;
    rx_char_o = 8'h00;
    rx_noise_o = 1'b0;
    rx_ferr_o = 1'b0;
  end
  // a framing fault goes out as a low stop bit
  task automatic send(input logic [7:0] c, input logic nz, input logic ferr);
    for (int i = 0; i < 10; i++) begin
      rxd_o <= (i == 0) ? 1'b0 : (i == 9) ? ~ferr : c[i - 1];
      repeat (bit_cyc) @(posedge clk_i);
    end
    rxd_o <= 1'b1;
    rx_char_o <= c;
    rx_noise_o <= nz;
    rx_ferr_o <= ferr;
    rx_valid_o <= 1'b1;
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    rx_char_o <= ~c;
  endtask
  // samples mid-bit, so any bit length of bit_cyc is accepted
  always begin
    @(negedge txd_i);
    repeat (bit_cyc / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_cyc) @(posedge clk_i);
      got_byte[i] = txd_i;
    end
    repeat (bit_cyc) @(posedge clk_i);
    got_stop = txd_i;
    if (listen_i)
      -> got;
  end
endmodule // usf_remote

// ===== tb/uart_status_flags_irq_tb.sv
// self-checking bench of the serial-port status block
`timescale 1ns/1ps
`include "usf_regs.svh"
module uart_status_flags_irq_tb;
  localparam logic [11:0] CT = `USF_OFF_CTRL;
  localparam logic [11:0] ST = `USF_OFF_STAT;
  localparam logic [11:0] TX = `USF_OFF_TXD;
  localparam logic [11:0] RX = `USF_OFF_RXD;
  localparam logic [11:0] BD = `USF_OFF_BAUD;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, rerr, txd, txd_oe_n, irq, rxd, rxv, nz, ferr;
  logic listen = 1'b1;
  logic [7:0] rxc, a, b;
  logic [7:0] expq[$];
  int mismatches = 0;
  int compares = 0;
  int seed = 32'h805AD88D;
  always #10 clk_i = ~clk_i;
  usf_status dut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .rx_char_valid_i(rxv), .rx_char_i(rxc),
    .rx_noise_i(nz), .rx_frame_err_i(ferr), .rxd_i(rxd), .txd_o(txd),
    .txd_oe_n_o(txd_oe_n), .irq_o(irq));
  usf_remote remote (.clk_i(clk_i), .txd_i(txd), .listen_i(listen), .rxd_o(rxd),
    .rx_valid_o(rxv), .rx_char_o(rxc), .rx_noise_o(nz), .rx_ferr_o(ferr));
  task automatic print_verdict;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // waits for pready however long it takes; only the watchdog ends a hang
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // status read arms the clear; a write into a full queue would overwrite it
  task automatic tx(input logic [7:0] c, input logic sent);
    do begin
      apb(1'b0, ST, 32'h0);
    end while (rdat[0] !== 1'b1);
    if (sent)
      expq.push_back(c);
    apb(1'b1, TX, {24'h0, c});
  endtask
  // bounded poll for the complete flag
  task automatic wait_tc;
    for (int i = 0; i < 200; i++) begin
      apb(1'b0, ST, 32'h0);
      if (rdat[1] === 1'b1)
        break;
    end
  endtask
  always @(remote.got) begin
    if (expq.size() == 0)
      chk({24'h0, remote.got_byte}, 32'h100);
    else
      chk({24'h0, remote.got_byte}, {24'h0, expq.pop_front()});
    chk({31'h0, remote.got_stop}, 32'h1);
  end
  initial begin
    #(20 * 40000);
    mismatches++;
    print_verdict;
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    chk({29'h0, txd, txd_oe_n, irq}, 32'h6);
    apb(1'b0, BD, 32'h0);
    chk(rdat, 32'h19);
    apb(1'b0, CT, 32'h0);
    chk(rdat, 32'h0);
    apb(1'b0, 12'h014, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    apb(1'b1, BD, 32'h1);
    apb(1'b1, CT, 32'h1);
    apb(1'b0, ST, 32'h0);
    chk({30'h0, rdat[1:0]}, 32'h3);
    chk({31'h0, txd_oe_n}, 32'h0);
    for (int i = 1; i < 3; i++) begin
      apb(1'b1, CT, 32'(1 | (1 << i)));
      repeat (2) @(posedge clk_i);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, CT, 32'h1);
      repeat (2) @(posedge clk_i);
      chk({31'h0, irq}, 32'h0);
    end
    tx(8'($random(seed)), 1'b1);
    tx(8'($random(seed)), 1'b1);
    apb(1'b0, ST, 32'h0);
    chk({30'h0, rdat[1:0]}, 32'h0);
    wait_tc;
    repeat (100) @(posedge clk_i);
    apb(1'b0, ST, 32'h0);
    chk({30'h0, rdat[1:0]}, 32'h3);
    // second byte is dropped from the queue when the enable drops
    tx(8'($random(seed)), 1'b1);
    tx(8'($random(seed)), 1'b0);
    apb(1'b1, CT, 32'h0);
    wait_tc;
    chk({30'h0, rdat[1:0]}, 32'h3);
    repeat (400) @(posedge clk_i);
    chk({31'h0, txd_oe_n}, 32'h1);
    apb(1'b1, CT, 32'h1);
    repeat (40) @(posedge clk_i);
    apb(1'b1, CT, 32'h0);
    repeat (20) @(posedge clk_i);
    chk({31'h0, txd_oe_n}, 32'h1);
    apb(1'b1, BD, 32'h2);
    remote.bit_cyc = 32;
    apb(1'b1, CT, 32'h1);
    apb(1'b0, ST, 32'h0);
    tx(8'($random(seed)), 1'b1);
    wait_tc;
    apb(1'b1, BD, 32'h1);
    remote.bit_cyc = 16;
    apb(1'b0, ST, 32'h0);
    apb(1'b1, TX, 32'($random(seed)) & 32'hFF);
    repeat (60) @(posedge clk_i);
    listen <= 1'b0;
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    #1 chk({30'h0, txd, txd_oe_n}, 32'h3);
    repeat (200) @(posedge clk_i);
    listen <= 1'b1;
    apb(1'b1, BD, 32'h1);
    apb(1'b1, CT, 32'h8);
    a = 8'($random(seed));
    b = 8'($random(seed));
    remote.send(a, 1'b1, 1'b0);
    apb(1'b0, ST, 32'h0);
    chk({28'h0, rdat[5:2]}, 32'h5);
    chk({31'h0, irq}, 32'h1);
    remote.send(b, 1'b0, 1'b0);
    apb(1'b0, ST, 32'h0);
    chk({28'h0, rdat[5:2]}, 32'h7);
    apb(1'b0, RX, 32'h0);
    chk({24'h0, rdat[7:0]}, {24'h0, a});
    apb(1'b0, ST, 32'h0);
    chk({30'h0, rdat[3:2]}, 32'h0);
    repeat (200) @(posedge clk_i);
    apb(1'b0, ST, 32'h0);
    chk({31'h0, rdat[6]}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, CT, 32'h10);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, RX, 32'h0);
    repeat (300) @(posedge clk_i);
    apb(1'b0, ST, 32'h0);
    chk({31'h0, rdat[6]}, 32'h0);
    apb(1'b1, CT, 32'h0);
    fork
      remote.send(b, 1'b0, 1'b1);
      begin
        repeat (60) @(posedge clk_i);
        apb(1'b0, ST, 32'h0);
        chk({31'h0, rdat[2]}, 32'h0);
      end
    join
    apb(1'b0, ST, 32'h0);
    chk({28'h0, rdat[5:2]}, 32'h9);
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, RX, 32'h0);
    chk({24'h0, rdat[7:0]}, {24'h0, b});
    chk(32'(expq.size()), 32'h0);
    print_verdict;
  end
endmodule // uart_status_flags_irq_tb
